// [core/pcs_top.sv]
/*
 * Printer configuration strap decode, thermal head strobe scheduler and
 * error clearing, with an APB register slave.
 * Assumes straps and sensor inputs synchronous to pclk, and sensors that
 * report comparator results (supply range, temperature thresholds).
 */
// Added by the designer: the register addresses and the APB slave port.
// What this block does
// - A dot line is six strobed blocks of sixty-four dots.
// - Fixed or variable division, chosen by strap or host command.
// - Fixed mode drives six 64-dot blocks, left first, fixed order.
// - Fixed mode drives set blocks in motor step one and two.
// - Variable: group blocks so each strobe holds at most 64 dots.
// - Variable: all strobes in step one; step two only feeds paper.
// - Drive strap low selects variable, high selects fixed.
// - Cutter strap low enables cutter, high disables it.
// - Carriage-return strap low makes CR a line feed, high ignores it.
// - Flow strap low XON/XOFF, high DTR/DSR, only for serial.
// - Auto-load strap low enables automatic paper loading.
// - Host code all high is parallel, else serial parity and baud.
// - Charset code all high JIS, down to all low USA.
// - Two density straps choose light, standard, slightly dark, dark.
// - No-paper clears when paper returns; auto load runs if enabled.
// - Head-up clears once the lever reads lowered.
// - Supply error clears only by feed switch or power-on, in range.
// - Temperature fault: cold clears at 0C, hot clears at 60C.
// - Cutter lock clears only by feed switch or power-on, jam gone.
// - Paper-out mid-print finishes the line, stops, resumes with paper.
`timescale 1ns/1ps
`default_nettype none
module pcs_top #(
	parameter int STROBE_LEN = pcs_pkg::STROBE_CYCLES,
	parameter int STEP_LEN = pcs_pkg::STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cutter_enable_strap,
	input wire logic cr_as_linefeed_strap,
	input wire logic density_strap_hi,
	input wire logic flow_ctrl_strap,
	input wire logic host_if_code_0,
	input wire logic host_if_code_1,
	input wire logic host_if_code_2,
	input wire logic host_if_code_3,
	input wire logic charset_code_0,
	input wire logic charset_code_1,
	input wire logic charset_code_2,
	input wire logic autoload_enable_strap,
	input wire logic head_drive_scheme_strap,
	input wire logic density_strap_lo,
	input wire logic paper_feed_switch,
	input wire logic paper_present,
	input wire logic head_lever_down,
	input wire logic head_motor_supply,
	input wire logic temp_below_0c,
	input wire logic temp_at_65c,
	input wire logic temp_at_60c,
	input wire logic cutter_locked,
	output logic [5:0] head_strobe,
	output logic motor_step,
	output logic line_done,
	output logic autoload_start,
	output logic print_error,
	output logic cutter_enable,
	output logic cr_as_linefeed,
	output logic xon_xoff_sel,
	output logic dtr_dsr_sel,
	output logic host_parallel,
	output logic [1:0] serial_parity,
	output logic [2:0] baud_sel,
	output logic [2:0] charset_sel,
	output logic autoload_enable,
	output logic [1:0] density_level,
	output logic variable_division
);
	// Dots set in one 64-dot block
	function automatic logic [6:0] dot_count(input logic [63:0] dots);
		logic [6:0] n;
		n = 7'h00;
		for (int i = 0; i < pcs_pkg::BLOCK_DOTS; i++) begin
			n = n + {6'h00, dots[i]};
		end
		return n;
	endfunction : dot_count

	logic [13:0] strap_ff;
	logic sampled_ff;
	logic [1:0] ctrl_ff;
	logic [31:0] line_mem [pcs_pkg::LINE_WORDS];
	logic pending_ff;
	logic nopaper_ff, headup_ff, supply_ff, cold_ff, hot_ff, cutter_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	pcs_pkg::pcs_state_type state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [2:0] blk_ff, nxt_blk;
	logic step_ff, nxt_step;
	logic [5:0] mask_ff, nxt_mask;
	logic [2:0] after_ff, nxt_after;
	logic done_ff, nxt_done;
	logic autoload_ff;

	// Straps caught once after reset release; the async reset loads a constant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_ff <= pcs_pkg::STRAP_RESET;
			sampled_ff <= 1'b0;
		end else if (!sampled_ff) begin
			strap_ff <= {density_strap_lo, head_drive_scheme_strap, autoload_enable_strap,
				charset_code_2, charset_code_1, charset_code_0, host_if_code_3,
				host_if_code_2, host_if_code_1, host_if_code_0, flow_ctrl_strap,
				density_strap_hi, cr_as_linefeed_strap, cutter_enable_strap};
			sampled_ff <= 1'b1;
		end
	end

	// Strap decode; all straps are active low
	wire [3:0] host_code = strap_ff[7:4];
	wire [3:0] host_idx = pcs_pkg::HOST_IDX_TOP - host_code;
	assign cutter_enable = !strap_ff[0];
	assign cr_as_linefeed = !strap_ff[1];
	assign host_parallel = host_code == pcs_pkg::HOST_PARALLEL_CODE;
	assign serial_parity = host_parallel ? 2'h0 : 2'(host_idx / pcs_pkg::BAUDS_PER_PARITY);
	assign baud_sel = host_parallel ? 3'h0 : 3'(host_idx % pcs_pkg::BAUDS_PER_PARITY);
	assign xon_xoff_sel = !host_parallel && !strap_ff[3];
	assign dtr_dsr_sel = !host_parallel && strap_ff[3];
	assign charset_sel = ~strap_ff[10:8];
	assign autoload_enable = !strap_ff[11];
	assign density_level = ~{strap_ff[2], strap_ff[13]};
	// Host command overrides the strap when its enable bit is set
	assign variable_division = ctrl_ff[pcs_pkg::CTRL_OVR_BIT]
		? ctrl_ff[pcs_pkg::CTRL_VAR_BIT] : !strap_ff[12];

	// APB decode; one wait state so read data comes from a flip-flop
	wire apb_acc = psel && penable;
	wire apb_done = apb_acc && pready_ff;
	wire wr_en = apb_done && pwrite && !pslverr_ff;
	wire hit_ctrl = paddr == pcs_pkg::CTRL_OFS;
	wire hit_status = paddr == pcs_pkg::STATUS_OFS;
	wire hit_config = paddr == pcs_pkg::CONFIG_OFS;
	wire hit_line = paddr >= pcs_pkg::LINE_OFS && paddr[1:0] == 2'h0
		&& paddr < pcs_pkg::LINE_OFS + 12'(4 * pcs_pkg::LINE_WORDS);
	wire [3:0] line_idx = 4'((paddr - pcs_pkg::LINE_OFS) >> 2);
	wire addr_ok = hit_ctrl || hit_status || hit_config || hit_line;
	wire busy = state_ff != pcs_pkg::ST_IDLE;
	wire err_any = nopaper_ff || headup_ff || supply_ff || cold_ff || hot_ff || cutter_ff;

	logic [31:0] status_word, config_word, rdata;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[pcs_pkg::ST_NOPAPER_BIT] = nopaper_ff;
		status_word[pcs_pkg::ST_HEADUP_BIT] = headup_ff;
		status_word[pcs_pkg::ST_SUPPLY_BIT] = supply_ff;
		status_word[pcs_pkg::ST_COLD_BIT] = cold_ff;
		status_word[pcs_pkg::ST_HOT_BIT] = hot_ff;
		status_word[pcs_pkg::ST_CUTTER_BIT] = cutter_ff;
		status_word[pcs_pkg::ST_BUSY_BIT] = busy;
		status_word[pcs_pkg::ST_PEND_BIT] = pending_ff;
		status_word[pcs_pkg::ST_SAMPLED_BIT] = sampled_ff;
		config_word = 32'h0000_0000;
		config_word[pcs_pkg::CF_CUTTER_BIT] = cutter_enable;
		config_word[pcs_pkg::CF_CRLF_BIT] = cr_as_linefeed;
		config_word[pcs_pkg::CF_XON_BIT] = xon_xoff_sel;
		config_word[pcs_pkg::CF_DTR_BIT] = dtr_dsr_sel;
		config_word[pcs_pkg::CF_PAR_BIT] = host_parallel;
		config_word[pcs_pkg::CF_PARITY_LO +: 2] = serial_parity;
		config_word[pcs_pkg::CF_BAUD_LO +: 3] = baud_sel;
		config_word[pcs_pkg::CF_CHARSET_LO +: 3] = charset_sel;
		config_word[pcs_pkg::CF_AUTOLOAD_BIT] = autoload_enable;
		config_word[pcs_pkg::CF_DENSITY_LO +: 2] = density_level;
		config_word[pcs_pkg::CF_VAR_BIT] = variable_division;
		if (hit_ctrl) begin
			rdata = {30'h0000_0000, ctrl_ff};
		end else if (hit_status) begin
			rdata = status_word;
		end else if (hit_config) begin
			rdata = config_word;
		end else if (hit_line) begin
			rdata = line_mem[line_idx];
		end else begin
			rdata = 32'h0000_0000;
		end
	end

	// APB answer: pready high in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= apb_acc && !pready_ff;
			pslverr_ff <= apb_acc && !pready_ff && !addr_ok;
			prdata_ff <= (apb_acc && !pready_ff && !pwrite) ? rdata : 32'h0000_0000;
		end
	end
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;

	// Control register and start request; a start waits while any error stands
	wire start_wr = wr_en && hit_ctrl && pwdata[pcs_pkg::CTRL_START_BIT];
	wire launch = !busy && pending_ff && !err_any;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= pcs_pkg::CTRL_RESET;
			pending_ff <= 1'b0;
		end else begin
			if (wr_en && hit_ctrl) begin
				ctrl_ff <= pwdata[1:0];
			end
			pending_ff <= start_wr || (pending_ff && !launch);
		end
	end

	// Line memory; software should not rewrite it while busy
	always_ff @(posedge pclk) begin
		if (wr_en && hit_line) begin
			line_mem[line_idx] <= pwdata;
		end
	end

	// Dot counts of the six 64-dot blocks
	logic [6:0] blk_dots [pcs_pkg::HEAD_BLOCKS];
	always_comb begin
		for (int b = 0; b < pcs_pkg::HEAD_BLOCKS; b++) begin
			blk_dots[b] = dot_count({line_mem[2 * b + 1], line_mem[2 * b]});
		end
	end

	// Next strobe group starting at block blk; fixed takes one, variable packs
	logic [5:0] grp_mask;
	logic [2:0] grp_after;
	logic [7:0] acc;
	logic stop;
	always_comb begin
		grp_mask = 6'h00;
		grp_after = 3'(pcs_pkg::HEAD_BLOCKS);
		acc = 8'h00;
		stop = 1'b0;
		for (int b = 0; b < pcs_pkg::HEAD_BLOCKS; b++) begin
			if (3'(b) >= nxt_blk && !stop) begin
				if (!variable_division) begin
					grp_mask[b] = 1'b1;
					grp_after = 3'(b + 1);
					stop = 1'b1;
				end else if (acc + {1'b0, blk_dots[b]} <= 8'(pcs_pkg::BLOCK_DOTS)) begin
					grp_mask[b] = 1'b1;
					acc = acc + {1'b0, blk_dots[b]};
					grp_after = 3'(b + 1);
				end else begin
					stop = 1'b1;
				end
			end
		end
	end

	// End of strobing for the current motor step
	wire fixed_split = !step_ff && after_ff == 3'(pcs_pkg::FIXED_SPLIT);
	wire step_end = after_ff == 3'(pcs_pkg::HEAD_BLOCKS) || (!variable_division && fixed_split);

	// Strobe scheduler
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + 16'h0001;
		nxt_blk = blk_ff;
		nxt_step = step_ff;
		nxt_done = 1'b0;
		unique case (state_ff)
			pcs_pkg::ST_IDLE: begin
				nxt_cnt = 16'h0000;
				if (launch) begin
					nxt_blk = 3'h0;
					nxt_step = 1'b0;
					nxt_state = pcs_pkg::ST_STROBE;
				end
			end
			pcs_pkg::ST_STROBE: begin
				if (cnt_ff == 16'(STROBE_LEN - 1)) begin
					nxt_cnt = 16'h0000;
					nxt_blk = after_ff;
					if (step_end) begin
						nxt_state = pcs_pkg::ST_STEP;
					end
				end
			end
			pcs_pkg::ST_STEP: begin
				if (cnt_ff == 16'(STEP_LEN - 1)) begin
					nxt_cnt = 16'h0000;
					nxt_step = 1'b1;
					if (step_ff) begin
						nxt_done = 1'b1;
						nxt_state = pcs_pkg::ST_IDLE;
					end else if (!variable_division) begin
						nxt_state = pcs_pkg::ST_STROBE;
					end // Variable mode: second step only feeds paper
				end
			end
			default: begin
				nxt_state = pcs_pkg::ST_IDLE;
			end
		endcase
	end

	// Group taken when a strobe phase opens; kept out of the scheduler to avoid a comb loop
	wire load_grp = nxt_state == pcs_pkg::ST_STROBE && nxt_cnt == 16'h0000;
	assign nxt_mask = load_grp ? grp_mask : mask_ff;
	assign nxt_after = load_grp ? grp_after : after_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= pcs_pkg::ST_IDLE;
			cnt_ff <= 16'h0000;
			blk_ff <= 3'h0;
			step_ff <= 1'b0;
			mask_ff <= 6'h00;
			after_ff <= 3'h0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			blk_ff <= nxt_blk;
			step_ff <= nxt_step;
			mask_ff <= nxt_mask;
			after_ff <= nxt_after;
			done_ff <= nxt_done;
		end
	end
	assign head_strobe = (state_ff == pcs_pkg::ST_STROBE) ? mask_ff : 6'h00;
	assign motor_step = state_ff == pcs_pkg::ST_STEP && cnt_ff == 16'h0000;
	assign line_done = done_ff;

	// Error flags: each clears only when its cause is gone, so a new cause wins
	wire feed_clear = paper_feed_switch && head_motor_supply;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nopaper_ff <= 1'b0;
			headup_ff <= 1'b0;
			supply_ff <= 1'b0;
			cold_ff <= 1'b0;
			hot_ff <= 1'b0;
			cutter_ff <= 1'b0;
			autoload_ff <= 1'b0;
		end else begin
			nopaper_ff <= !paper_present;
			headup_ff <= !head_lever_down;
			supply_ff <= !head_motor_supply || (supply_ff && !feed_clear);
			cold_ff <= temp_below_0c;
			hot_ff <= temp_at_65c || (hot_ff && !temp_at_60c);
			cutter_ff <= (cutter_enable && cutter_locked)
				|| (cutter_ff && !(paper_feed_switch && !cutter_locked));
			autoload_ff <= nopaper_ff && paper_present && autoload_enable;
		end
	end
	assign autoload_start = autoload_ff;
	assign print_error = err_any;
endmodule : pcs_top
`default_nettype wire

// [core/pcs_pkg.sv]
/*
 * Shared constants for the printer configuration and head strobe block:
 * register offsets, field positions, reset values, timing counts, states.
 * Assumes a 125 MHz pclk and 32-bit APB with byte addresses.
 */
`default_nettype none
package pcs_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int STROBE_TIME_NS = 1000;
	localparam int STEP_TIME_NS = 2000;
	localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Head geometry
	localparam int HEAD_BLOCKS = 6;
	localparam int BLOCK_DOTS = 64;
	localparam int LINE_WORDS = 12;
	localparam int FIXED_SPLIT = 3;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] CONFIG_OFS = 12'h008;
	localparam logic [11:0] LINE_OFS = 12'h040;
	// CTRL fields
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_VAR_BIT = 1;
	localparam int CTRL_START_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// STATUS fields
	localparam int ST_NOPAPER_BIT = 0;
	localparam int ST_HEADUP_BIT = 1;
	localparam int ST_SUPPLY_BIT = 2;
	localparam int ST_COLD_BIT = 3;
	localparam int ST_HOT_BIT = 4;
	localparam int ST_CUTTER_BIT = 5;
	localparam int ST_BUSY_BIT = 8;
	localparam int ST_PEND_BIT = 9;
	localparam int ST_SAMPLED_BIT = 10;
	// CONFIG fields (low bit positions)
	localparam int CF_CUTTER_BIT = 0;
	localparam int CF_CRLF_BIT = 1;
	localparam int CF_XON_BIT = 2;
	localparam int CF_DTR_BIT = 3;
	localparam int CF_PAR_BIT = 4;
	localparam int CF_PARITY_LO = 5;
	localparam int CF_BAUD_LO = 8;
	localparam int CF_CHARSET_LO = 12;
	localparam int CF_AUTOLOAD_BIT = 16;
	localparam int CF_DENSITY_LO = 17;
	localparam int CF_VAR_BIT = 20;
	// Strap reset value: every strap reads high when open
	localparam logic [13:0] STRAP_RESET = 14'h3FFF;
	localparam logic [3:0] HOST_PARALLEL_CODE = 4'hF;
	localparam logic [3:0] HOST_IDX_TOP = 4'hE;
	localparam logic [3:0] BAUDS_PER_PARITY = 4'h5;
	// Scheduler states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STROBE = 2'b01,
		ST_STEP = 2'b10
	} pcs_state_type;
endpackage : pcs_pkg
`default_nettype wire

// [tb/pcs_top_assertions.sv]
/*
 * Concurrent checks on the ports of the strobe, strap and error block.
 * Assumes binding into pcs_top and the bench's strobe length parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module pcs_top_assertions #(
	parameter int STROBE_LEN = 125,
	parameter int STEP_LEN = 250
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic paper_present,
	input wire logic head_motor_supply,
	input wire logic temp_at_65c,
	input wire logic [5:0] head_strobe,
	input wire logic motor_step,
	input wire logic autoload_start,
	input wire logic print_error,
	input wire logic cutter_enable,
	input wire logic xon_xoff_sel,
	input wire logic dtr_dsr_sel,
	input wire logic host_parallel,
	input wire logic [2:0] baud_sel,
	input wire logic [2:0] charset_sel,
	input wire logic autoload_enable,
	input wire logic [1:0] density_level,
	input wire logic variable_division
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [5:0] prev_ff;
	logic [15:0] run_ff;
	logic [1:0] up_ff;
	logic [15:0] nxt_run;
	logic [1:0] nxt_up;
	// Length of the current strobe group; a new mask restarts the count
	assign nxt_run = (head_strobe == 6'h00) ? 16'h0000 :
		((head_strobe == prev_ff) ? run_ff + 16'h0001 : 16'h0001);
	assign nxt_up = (up_ff == 2'h2) ? 2'h2 : up_ff + 2'h1;
	// Helper flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= 6'h00;
			run_ff <= 16'h0000;
			up_ff <= 2'h0;
		end else begin
			prev_ff <= head_strobe;
			run_ff <= nxt_run;
			up_ff <= nxt_up;
		end
	end
	apb_one_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	slverr_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	fixed_single_block_a: assert property (!variable_division |-> $onehot0(head_strobe))
		else $error("several blocks strobed in fixed mode");
	strobe_len_a: assert property (run_ff <= STROBE_LEN)
		else $error("strobe group too long");
	straps_held_a: assert property (up_ff == 2'h2 |-> $stable({cutter_enable,
		xon_xoff_sel, dtr_dsr_sel, host_parallel, baud_sel, charset_sel, autoload_enable,
		density_level}))
		else $error("decoded settings changed after capture");
	flow_serial_a: assert property (host_parallel |-> !xon_xoff_sel && !dtr_dsr_sel)
		else $error("flow control selected on parallel host");
	flow_one_a: assert property (!host_parallel |-> xon_xoff_sel ^ dtr_dsr_sel)
		else $error("serial flow control not exactly one kind");
	baud_range_a: assert property (baud_sel <= 3'h4)
		else $error("baud select out of range");
	autoload_gate_a: assert property (autoload_start |-> autoload_enable ##1 !autoload_start)
		else $error("auto load start without enable or not a pulse");
	nopaper_err_a: assert property (!paper_present |=> print_error)
		else $error("no paper not flagged");
	supply_err_a: assert property (!head_motor_supply |=> print_error)
		else $error("supply fault not flagged");
	hot_err_a: assert property (temp_at_65c |=> print_error)
		else $error("hot head not flagged");
	step_pulse_a: assert property (motor_step |=> !motor_step)
		else $error("motor step not a pulse");
endmodule : pcs_top_assertions
bind pcs_top pcs_top_assertions #(.STROBE_LEN(STROBE_LEN), .STEP_LEN(STEP_LEN)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .paper_present(paper_present), .head_motor_supply(head_motor_supply),
	.temp_at_65c(temp_at_65c), .head_strobe(head_strobe), .motor_step(motor_step),
	.autoload_start(autoload_start), .print_error(print_error),
	.cutter_enable(cutter_enable), .xon_xoff_sel(xon_xoff_sel), .dtr_dsr_sel(dtr_dsr_sel),
	.host_parallel(host_parallel), .baud_sel(baud_sel), .charset_sel(charset_sel),
	.autoload_enable(autoload_enable), .density_level(density_level),
	.variable_division(variable_division));
`default_nettype wire

// [tb/pcs_mech_model.sv]
/*
 * Jumper field and thermal head mechanism model: drives the active-low
 * straps and records which blocks fired in each motor step.
 * Assumes two motor_step pulses per dot line, strobes before the first step and, in fixed mode only, before the second.
 */
`timescale 1ns/1ps
`default_nettype none
module pcs_mech_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [13:0] strap_word,
	output logic [13:0] strap_pins,
	input wire logic [5:0] head_strobe,
	input wire logic motor_step,
	output logic [5:0] step1_mask,
	output logic [5:0] step2_mask
);
	logic [5:0] acc_ff;
	logic second_ff;
	// A closed jumper grounds the pin, an open one reads high
	assign strap_pins = strap_word;
	// Blocks energised since the last step, latched at each step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= 6'h00;
			second_ff <= 1'b0;
			step1_mask <= 6'h00;
			step2_mask <= 6'h00;
		end else if (motor_step) begin
			acc_ff <= 6'h00;
			second_ff <= !second_ff;
			if (second_ff) step2_mask <= acc_ff | head_strobe;
			else step1_mask <= acc_ff | head_strobe;
		end else begin
			acc_ff <= acc_ff | head_strobe;
		end
	end
endmodule : pcs_mech_model
`default_nettype wire

// [tb/test_printer_config_and_head_strobe.sv]
/*
 * Self-checking bench: strap decode, fixed and variable strobing, error
 * clearing and APB access. Assumes short strobe and step lengths.
 */
`timescale 1ns/1ps
`default_nettype none
module test_printer_config_and_head_strobe;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, se, motor_step, line_done, autoload_start, print_error;
	logic paper_present = 1'b1, head_lever_down = 1'b1, head_motor_supply = 1'b1;
	logic feed = 1'b0, cold = 1'b0, hot = 1'b0, below60 = 1'b1, jam = 1'b0;
	logic [13:0] strap_word = 14'h3FFF, sp;
	logic [5:0] head_strobe, m1, m2, first_mask;
	logic cutter_enable, cr_as_linefeed, xon_xoff_sel, dtr_dsr_sel, host_parallel;
	logic [1:0] serial_parity, density_level;
	logic [2:0] baud_sel, charset_sel;
	logic autoload_enable, variable_division;
	int n_errors = 0, cmp_count = 0, cyc = 0, n_strobe = 0;
	initial forever #4 pclk = ~pclk;
	pcs_mech_model u_mech (.pclk(pclk), .presetn(presetn), .strap_word(strap_word),
		.strap_pins(sp), .head_strobe(head_strobe), .motor_step(motor_step),
		.step1_mask(m1), .step2_mask(m2));
	pcs_top #(.STROBE_LEN(3), .STEP_LEN(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cutter_enable_strap(sp[0]),
		.cr_as_linefeed_strap(sp[1]), .density_strap_hi(sp[2]), .flow_ctrl_strap(sp[3]),
		.host_if_code_0(sp[4]), .host_if_code_1(sp[5]), .host_if_code_2(sp[6]),
		.host_if_code_3(sp[7]), .charset_code_0(sp[8]), .charset_code_1(sp[9]),
		.charset_code_2(sp[10]), .autoload_enable_strap(sp[11]),
		.head_drive_scheme_strap(sp[12]), .density_strap_lo(sp[13]),
		.paper_feed_switch(feed), .paper_present(paper_present),
		.head_lever_down(head_lever_down), .head_motor_supply(head_motor_supply),
		.temp_below_0c(cold), .temp_at_65c(hot), .temp_at_60c(below60), .cutter_locked(jam),
		.head_strobe(head_strobe), .motor_step(motor_step), .line_done(line_done),
		.autoload_start(autoload_start), .print_error(print_error),
		.cutter_enable(cutter_enable), .cr_as_linefeed(cr_as_linefeed),
		.xon_xoff_sel(xon_xoff_sel), .dtr_dsr_sel(dtr_dsr_sel), .host_parallel(host_parallel),
		.serial_parity(serial_parity), .baud_sel(baud_sel), .charset_sel(charset_sel),
		.autoload_enable(autoload_enable), .density_level(density_level),
		.variable_division(variable_division));
	task automatic give_verdict();
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Hang guard well above the few hundred cycles the sequence needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check(n < 50, 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic restart(input logic [13:0] w);
		@(posedge pclk);
		presetn <= 1'b0; strap_word <= w;
		tick(2);
		presetn <= 1'b1;
		tick(3);
	endtask : restart
	// Strap decode over every host code, other straps following its bits
	task automatic t_straps();
		logic [13:0] w;
		int idx;
		for (int i = 0; i < 16; i++) begin
			w = {i[1], i[0], i[3], i[2:0], i[3:0], i[3], i[1], i[2], i[0]};
			restart(w);
			idx = 14 - i;
			check(host_parallel, i == 15);
			if (i != 15) check({serial_parity, baud_sel}, {2'(idx / 5), 3'(idx % 5)});
			check(charset_sel, 3'h7 - 3'(i));
			check(density_level, {~w[2], ~w[13]});
			check({cutter_enable, cr_as_linefeed, autoload_enable, variable_division},
				{~w[0], ~w[1], ~w[11], ~w[12]});
			check({xon_xoff_sel, dtr_dsr_sel}, (i == 15) ? 2'b00 : {~w[3], w[3]});
			strap_word <= ~w;
			tick(3);
			check(charset_sel, 3'h7 - 3'(i));
		end
	endtask : t_straps
	task automatic run_line(input logic [31:0] ctrl);
		int n;
		apb(1'b1, pcs_pkg::CTRL_OFS, ctrl);
		n = 0;
		n_strobe = 0;
		first_mask = 6'h00;
		do begin
			@(posedge pclk);
			n++;
			if (head_strobe != 6'h00) n_strobe++;
			if (first_mask == 6'h00) first_mask = head_strobe;
		end while (line_done !== 1'b1 && n < 300);
		check(n < 300, 1'b1);
		tick(2);
	endtask : run_line
	// Fixed then variable division of one dot line
	task automatic t_strobe();
		restart(14'h3FFF);
		for (int w = 0; w < 12; w++) apb(1'b1, pcs_pkg::LINE_OFS + 12'(4 * w), 32'hFFFFFFFF);
		run_line(32'h00000004);
		check({m2, m1}, {6'h38, 6'h07});
		check(first_mask, 6'h01);
		check(n_strobe, 6 * 3);
		for (int w = 0; w < 12; w++) apb(1'b1, pcs_pkg::LINE_OFS + 12'(4 * w),
			(w == 0 || w == 2 || w == 6 || w == 7) ? 32'hFFFFFFFF : (w == 8) ? 32'h1 : 0);
		run_line(32'h00000007);
		check(variable_division, 1'b1);
		check({m2, m1}, {6'h00, 6'h3F});
		check(first_mask, 6'h07);
		check(n_strobe, 3 * 3);
		apb(1'b0, 12'h0F0, 32'h0);
		check(se, 1'b1);
		check(rd, 32'h00000000);
		apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0);
		check(rd[pcs_pkg::ST_SAMPLED_BIT], 1'b1);
	endtask : t_strobe
	task automatic err_is(input logic e);
		tick(3);
		check(print_error, e);
	endtask : err_is
	task automatic press_feed();
		feed <= 1'b1;
		tick(3);
		feed <= 1'b0;
	endtask : press_feed
	// Error set and clear paths with auto load and cutter enabled
	task automatic t_errors();
		int seen;
		restart(14'h37FE);
		paper_present <= 1'b0;
		err_is(1'b1);
		seen = 0;
		paper_present <= 1'b1;
		repeat (6) begin
			@(posedge pclk);
			if (autoload_start === 1'b1) seen++;
		end
		check(seen, 1);
		check(print_error, 1'b0);
		head_lever_down <= 1'b0;
		err_is(1'b1);
		head_lever_down <= 1'b1;
		err_is(1'b0);
		head_motor_supply <= 1'b0;
		err_is(1'b1);
		head_motor_supply <= 1'b1;
		err_is(1'b1);
		press_feed();
		err_is(1'b0);
		hot <= 1'b1; below60 <= 1'b0;
		err_is(1'b1);
		hot <= 1'b0;
		err_is(1'b1);
		below60 <= 1'b1;
		err_is(1'b0);
		cold <= 1'b1;
		err_is(1'b1);
		cold <= 1'b0;
		err_is(1'b0);
		jam <= 1'b1;
		err_is(1'b1);
		jam <= 1'b0;
		err_is(1'b1);
		press_feed();
		err_is(1'b0);
	endtask : t_errors
	initial begin
		tick(6);
		presetn <= 1'b1;
		tick(2);
		t_straps();
		t_strobe();
		t_errors();
		give_verdict();
	end
endmodule : test_printer_config_and_head_strobe
`default_nettype wire
